// ---- rtcss_pkg.sv ----
package rtcss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map and control register layout
  localparam logic [5:0] CTRL_ADDR       = 6'h07;
  localparam logic [5:0] PTR_LAST        = 6'h3f;
  localparam logic [5:0] PTR_FIRST       = 6'h00;
  localparam logic [7:0] CTRL_RESET      = 8'hb3;
  localparam int         IDLE_LEVEL_BIT  = 7;
  localparam int         OSF_BIT         = 5;
  localparam int         SQUARE_WAVE_ENABLE_BIT        = 4;
  localparam int         RS_HIGH_BIT     = 1;
  localparam int         RS_LOW_BIT      = 0;

  ////////////////////////////////////////////////////////////////////////////
  // serial link
  localparam logic [6:0] SLAVE_ADDR      = 7'h68;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // rate select codes and divider taps (osc_clk ticks at 65.536 kHz)
  localparam logic [1:0] RS_1HZ          = 2'h0;
  localparam logic [1:0] RS_4K096        = 2'h1;
  localparam logic [1:0] RS_8K192        = 2'h2;
  localparam logic [1:0] RS_32K768       = 2'h3;
  localparam int         TAP_1HZ         = 15;
  localparam int         TAP_4K096       = 3;
  localparam int         TAP_8K192       = 2;
  localparam int         TAP_32K768      = 0;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int         REF_CLK_PERIOD_NS   = 4;
  localparam int         OSC_STOP_TIMEOUT_NS = 32000;
  localparam int         OSC_STOP_CYCLES_DEF = OSC_STOP_TIMEOUT_NS / REF_CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_PTR   = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_SPARE = 6'h20
  } rtcss_state_t;

endpackage : rtcss_pkg

// ---- rtcss_slave_top.sv ----
// Contract
// R1 - control register sits at pointer address 07h.
// R2 - square wave disabled: pin shows idle_output_level, bit 7.
// R3 - osc_stopped_flag, bit 5, sets when oscillator goes from running to stopped.
// R4 - osc_stopped_flag stays set until written 0; writing 1 leaves it.
// R5 - square_wave_enable, bit 4, puts oscillator-derived square wave on the pin.
// R6 - rate bits: 00 1Hz, 01 4.096k, 10 8.192k, 11 32.768k.
// R7 - the master makes SCL, START and STOP; slave never drives clock.
// R8 - slave works at 100 kHz and 400 kHz serial clock.
// R9 - master starts transfers only while SDA and SCL both high.
// R10 - SDA changes only while SCL low; changes while high are conditions.
// R11 - START is SDA falling while SCL high.
// R12 - STOP is SDA rising while SCL high; it ends the transfer.
// R13 - any number of bytes between START and STOP, master decides.
// R14 - bytes are eight bits, MSB first, plus ninth acknowledge bit.
// R15 - master supplies a ninth clock pulse for each acknowledge.
// R16 - acknowledger holds SDA low through the whole ack clock high.
// R17 - read ends on master not-acknowledge; slave then releases SDA.
// R18 - slave acknowledges address byte and every written byte.
// R19 - master acknowledges each read byte except the last.
// R20 - repeated START begins new transfer; slave decodes a fresh address.
// R21 - slave answers only address 1101000, direction bit after it.
// R22 - first written byte loads pointer; pointer increments per data byte.
// R23 - read starts at current pointer, incrementing after each byte sent.
// R24 - pointer wraps from 3Fh to 00h.
// R25 - control bits 6, 3, 2 read zero; writes ignored.
// R26 - square wave frequencies divide down the oscillator clock.
module rtcss_slave_top
  import rtcss_pkg::*;
#(
  parameter int OSC_STOP_CYCLES = OSC_STOP_CYCLES_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       osc_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            square_wave_pin,
  output logic [5:0]      reg_addr,
  input  wire logic [7:0] reg_rd_data,
  output logic            reg_wr_stb,
  output logic [7:0]      reg_wr_data
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [1:0]   scl_sync;
    logic [1:0]   sda_sync;
    logic         scl_d;
    logic         sda_d;
    rtcss_state_t state;
    logic         ack;
    logic [3:0]   bitcnt;
    logic [7:0]   shreg;
    logic         rw;
    logic [5:0]   ptr;
    logic         sda_oe;
    logic         idle_level;
    logic         osc_stopped_flag;
    logic         square_wave_enable;
    logic [1:0]   rs;
    logic [1:0]   tgl_sync;
    logic         tgl_d;
    logic         running;
    logic [13:0]  idle_cnt;
    logic [1:0]   wave_sync;
    logic         sqw;
    logic         wr_stb;
    logic [7:0]   wr_data;
  } rtcss_ref_t;
  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [1:0]  rs_s0;
    logic [1:0]  rs_s1;
    logic [15:0] div;
    logic        wave;
  } rtcss_osc_t;

  rtcss_ref_t q;
  rtcss_ref_t next_q;
  rtcss_osc_t o;
  rtcss_osc_t next_o;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic ctrl_wr;
  logic osf_set;
  logic [7:0] ctrl_byte;
  logic [7:0] rd_byte;
  localparam logic [13:0] STOP_CNT = 14'(OSC_STOP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] read_mux(input logic [5:0] ptr,
                                          input logic [7:0] ctrl,
                                          input logic [7:0] ext);
    read_mux = (ptr == CTRL_ADDR) ? ctrl : ext;
  endfunction
  function automatic logic pick_tap(input logic [1:0] rs, input logic [15:0] div);
    case (rs)
      RS_1HZ:    pick_tap = div[TAP_1HZ];
      RS_4K096:  pick_tap = div[TAP_4K096];
      RS_8K192:  pick_tap = div[TAP_8K192];
      RS_32K768: pick_tap = div[TAP_32K768];
      default:   pick_tap = 1'b0;
    endcase
  endfunction

  // synchronised copies only; the first stage is never looked at here
  assign scl_rise   = q.scl_sync[1] & ~q.scl_d;
  assign scl_fall   = ~q.scl_sync[1] & q.scl_d;
  assign start_cond = q.scl_sync[1] & q.scl_d & q.sda_d & ~q.sda_sync[1];  // [R11]
  assign stop_cond  = q.scl_sync[1] & q.scl_d & ~q.sda_d & q.sda_sync[1];  // [R12]
  assign ctrl_byte  = {q.idle_level, 1'b0, q.osc_stopped_flag, q.square_wave_enable, 2'b00, q.rs};      // [R25]
  assign rd_byte    = read_mux(q.ptr, ctrl_byte, reg_rd_data);              // [R23]

  ////////////////////////////////////////////////////////////////////////////
  // reference domain: serial slave, control register, stop detector

  always_comb begin
    next_q          = q;
    ctrl_wr         = 1'b0;
    osf_set         = 1'b0;
    next_q.wr_stb   = 1'b0;
    next_q.scl_sync = {q.scl_sync[0], scl_in};  // [R8]
    next_q.sda_sync = {q.sda_sync[0], sda_in};
    next_q.scl_d    = q.scl_sync[1];
    next_q.sda_d    = q.sda_sync[1];

    if (start_cond) begin  // [R20]
      next_q.state  = ST_ADDR;
      next_q.ack    = 1'b0;
      next_q.bitcnt = 4'h0;
      next_q.sda_oe = 1'b0;
    end else if (stop_cond) begin  // [R12]
      next_q.state  = ST_IDLE;
      next_q.ack    = 1'b0;
      next_q.sda_oe = 1'b0;
    end else begin
      case (q.state)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise && !q.ack) begin  // [R14]
            next_q.shreg  = {q.shreg[6:0], q.sda_sync[1]};
            next_q.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && !q.ack && q.bitcnt == BITS_PER_BYTE) begin
            next_q.ack    = 1'b1;
            next_q.sda_oe = 1'b1;  // [R18]
            if (q.state == ST_ADDR) begin
              next_q.rw = q.shreg[0];
              if (q.shreg[7:1] != SLAVE_ADDR) begin  // [R21]
                next_q.state  = ST_IDLE;
                next_q.ack    = 1'b0;
                next_q.sda_oe = 1'b0;
              end
            end else if (q.state == ST_PTR) begin
              next_q.ptr = q.shreg[5:0];  // [R22]
            end else begin
              // the write lands on the acknowledge, in the same cycle as the pointer moves on
              if (q.ptr == CTRL_ADDR) begin  // [R1]
                ctrl_wr = 1'b1;
              end else begin
                next_q.wr_stb  = 1'b1;
                next_q.wr_data = q.shreg;
              end
              next_q.ptr = q.ptr + 6'h01;  // [R22] [R24]
            end
          end else if (scl_fall && q.ack) begin  // [R16]
            next_q.ack    = 1'b0;
            next_q.sda_oe = 1'b0;
            next_q.bitcnt = 4'h0;
            if (q.state == ST_ADDR && q.rw) begin
              next_q.state  = ST_RDATA;
              next_q.shreg  = rd_byte;
              next_q.sda_oe = ~rd_byte[7];
            end else if (q.state == ST_ADDR) begin
              next_q.state = ST_PTR;
            end else begin
              next_q.state = ST_WDATA;  // [R13]
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            if (q.ack && q.sda_sync[1]) begin
              next_q.state = ST_IDLE;  // [R17]
            end else if (!q.ack) begin
              next_q.bitcnt = q.bitcnt + 4'h1;
            end
          end else if (scl_fall) begin
            if (q.ack) begin
              next_q.ack    = 1'b0;
              next_q.bitcnt = 4'h0;
              next_q.shreg  = rd_byte;
              next_q.sda_oe = ~rd_byte[7];
            end else if (q.bitcnt == BITS_PER_BYTE) begin
              next_q.sda_oe = 1'b0;
              next_q.ack    = 1'b1;
              next_q.ptr    = q.ptr + 6'h01;  // [R23] [R24]
            end else begin
              next_q.shreg  = {q.shreg[6:0], 1'b0};
              next_q.sda_oe = ~q.shreg[6];  // [R10]
            end
          end
        end
        default: begin
          next_q.state  = ST_IDLE;
          next_q.ack    = 1'b0;
          next_q.sda_oe = 1'b0;
        end
      endcase
    end

    if (ctrl_wr) begin  // [R25]
      next_q.idle_level = q.shreg[IDLE_LEVEL_BIT];
      next_q.square_wave_enable       = q.shreg[SQUARE_WAVE_ENABLE_BIT];
      next_q.rs         = {q.shreg[RS_HIGH_BIT], q.shreg[RS_LOW_BIT]};
      if (!q.shreg[OSF_BIT]) begin
        next_q.osc_stopped_flag = 1'b0;  // [R4]
      end
    end

    // no toggle from the divider for the timeout means the oscillator stopped
    next_q.tgl_sync = {q.tgl_sync[0], o.div[TAP_32K768]};
    next_q.tgl_d    = q.tgl_sync[1];
    if (q.tgl_sync[1] != q.tgl_d) begin
      next_q.idle_cnt = 14'h0000;
      next_q.running  = 1'b1;
    end else if (q.idle_cnt == STOP_CNT) begin
      next_q.running = 1'b0;
      osf_set        = q.running;  // [R3]
    end else begin
      next_q.idle_cnt = q.idle_cnt + 14'h0001;
    end
    if (osf_set) begin
      next_q.osc_stopped_flag = 1'b1;  // [R3] [R4]
    end

    next_q.wave_sync = {q.wave_sync[0], o.wave};
    next_q.sqw       = q.square_wave_enable ? q.wave_sync[1] : q.idle_level;  // [R2] [R5]
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q            <= '0;
      q.scl_sync   <= 2'h3;
      q.sda_sync   <= 2'h3;
      q.scl_d      <= 1'b1;
      q.sda_d      <= 1'b1;
      q.state      <= ST_IDLE;
      q.idle_level <= CTRL_RESET[IDLE_LEVEL_BIT];
      q.osc_stopped_flag        <= CTRL_RESET[OSF_BIT];
      q.square_wave_enable       <= CTRL_RESET[SQUARE_WAVE_ENABLE_BIT];
      q.rs         <= {CTRL_RESET[RS_HIGH_BIT], CTRL_RESET[RS_LOW_BIT]};
      q.sqw        <= CTRL_RESET[IDLE_LEVEL_BIT];
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator domain: divider chain; rate bits cross as a slow level pair,
  // so a one-tick glitch during a rate change is accepted

  always_comb begin
    next_o          = o;
    next_o.rst_sync = {o.rst_sync[0], srst};
    next_o.rs_s0    = q.rs;
    next_o.rs_s1    = o.rs_s0;
    if (o.rst_sync[1]) begin
      next_o.div  = 16'h0000;
      next_o.wave = 1'b0;
    end else begin
      next_o.div  = o.div + 16'h0001;           // [R26]
      next_o.wave = pick_tap(o.rs_s1, o.div);   // [R6]
    end
  end

  always_ff @(posedge osc_clk) begin
    o <= next_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the slave only ever pulls SDA, never SCL

  assign sda_out         = 1'b0;  // [R7]
  assign sda_oe          = q.sda_oe;
  assign square_wave_pin = q.sqw;
  assign reg_addr        = q.ptr;
  assign reg_wr_stb      = q.wr_stb;
  assign reg_wr_data     = q.wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence addr_match_s;
    q.state == ST_ADDR && !q.ack && q.bitcnt == BITS_PER_BYTE && scl_fall &&
      q.shreg[7:1] == SLAVE_ADDR && !start_cond && !stop_cond;
  endsequence

  sequence ack_driven_s;
    q.sda_oe && q.ack;
  endsequence

  ctrl_write_a: assert property (ctrl_wr |=> q.square_wave_enable == $past(q.shreg[SQUARE_WAVE_ENABLE_BIT]) &&  // [R1]
      q.rs == $past(q.shreg[1:0]))
    else $error("control write not stored");
  static_level_a: assert property (!$past(srst) && !$past(q.square_wave_enable) |->  // [R2]
      square_wave_pin == $past(q.idle_level))
    else $error("static level wrong");
  osf_set_a: assert property (osf_set |=> q.osc_stopped_flag)  // [R3]
    else $error("stop flag not set");
  osf_sticky_a: assert property (q.osc_stopped_flag && !(ctrl_wr && !q.shreg[OSF_BIT]) |=> q.osc_stopped_flag)  // [R4]
    else $error("stop flag lost");
  wave_out_a: assert property (!$past(srst) && $past(q.square_wave_enable) |->  // [R5]
      square_wave_pin == $past(q.wave_sync[1]))
    else $error("square wave not routed");
  rate_tap_a: assert property (@(posedge osc_clk) disable iff (o.rst_sync[1])  // [R6]
      !$past(o.rst_sync[1]) |-> o.wave == pick_tap($past(o.rs_s1), $past(o.div)))
    else $error("rate tap wrong");
  sda_change_a: assert property ($changed(q.sda_oe) |-> !$past(q.scl_sync[1]))  // [R10]
    else $error("sda moved while scl high");
  start_a: assert property (start_cond |=> q.state == ST_ADDR && q.bitcnt == 4'h0)  // [R11]
    else $error("start missed");
  stop_a: assert property (stop_cond |=> q.state == ST_IDLE && !q.sda_oe)  // [R12]
    else $error("stop missed");
  addr_ack_a: assert property (addr_match_s |=> ack_driven_s)  // [R21]
    else $error("address not acknowledged");
  ptr_wrap_a: assert property (q.ptr == PTR_LAST && next_q.ptr != q.ptr &&  // [R24]
      !ctrl_wr && q.state != ST_PTR |=> q.ptr == PTR_FIRST)
    else $error("pointer did not wrap");

endmodule : rtcss_slave_top

// ---- rtcss_master_model.sv ----
module rtcss_master_model (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl_m,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 100ps;

  int half     = 16;
  int hold_err = 0;

  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // data moves a quarter of a half period into the low phase, never on the falling edge itself
  task automatic pulse(input logic b, output logic r);
    tick(half / 4);
    sda_m = b;
    tick(half);
    scl_m = 1'b1;
    tick(2);
    r = sda;
    tick(half - 2);
    if (sda !== r) hold_err++;
    scl_m = 1'b0;
  endtask

  task automatic start_cond();
    tick(half / 4);
    sda_m = 1'b1;
    tick(half);
    scl_m = 1'b1;
    tick(half);
    sda_m = 1'b0;
    tick(half);
    scl_m = 1'b0;
  endtask

  task automatic stop_cond();
    tick(half / 4);
    sda_m = 1'b0;
    tick(half);
    scl_m = 1'b1;
    tick(half);
    sda_m = 1'b1;
    tick(half);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) pulse(d[i], r);
    pulse(1'b1, r);
    ack = ~r;
  endtask

  // the last byte of a read is refused so the slave lets go of the line
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, r);
      d[i] = r;
    end
    pulse(last, r);
  endtask
endmodule // rtcss_master_model

// ---- rtcss_tb_top.sv ----
module rtc_serial_slave_sqw_control_tb_top
  import rtcss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int STOP_CYC = 16;
  localparam int LIMIT    = 80000;

  logic       ref_clk = 1'b0;
  logic       osc_clk;
  logic       osc_run;
  logic       srst;
  logic       scl, sda, scl_m, sda_m, sda_out, sda_oe, square_wave_pin, reg_wr_stb;
  logic       scl_q, oe_q;
  logic [5:0] reg_addr;
  logic [7:0] reg_wr_data, reg_rd_data;
  logic [7:0] ext_mem [64];
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  int         error_cnt = 0;
  int         n_checks  = 0;
  int         cycles    = 0;
  int         hz [4]    = '{1, 4096, 8192, 32768};
  logic [7:0] rexp [3]  = '{8'ha2, 8'ha3, 8'h5b};

  always #2 ref_clk = ~ref_clk;
  initial begin
    osc_clk = 1'b0;
    #3;
    forever #6 if (osc_run) osc_clk = ~osc_clk;
  end

  assign scl         = scl_m;
  assign sda         = sda_m & ~(sda_oe === 1'b1 && sda_out === 1'b0);
  assign reg_rd_data = ext_mem[reg_addr];

  rtcss_slave_top #(.OSC_STOP_CYCLES(STOP_CYC)) dut (
    .ref_clk(ref_clk), .srst(srst), .osc_clk(osc_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .square_wave_pin(square_wave_pin),
    .reg_addr(reg_addr), .reg_rd_data(reg_rd_data), .reg_wr_stb(reg_wr_stb),
    .reg_wr_data(reg_wr_data));
  rtcss_master_model m (.ref_clk(ref_clk), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));

  ////////////////////////////////////////////////////////////////////////////
  // strobe lands one past its target, the pointer has already moved on
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    scl_q  <= scl;
    oe_q   <= sda_oe;
    if (reg_wr_stb === 1'b1) ext_mem[reg_addr - 6'h01] <= reg_wr_data;
    if (srst === 1'b0 && scl && scl_q && sda_oe !== oe_q) begin
      error_cnt++;
      $display("[FAIL] sda_oe during scl high expected %b got %b", oe_q, sda_oe);
    end
    if (cycles == LIMIT) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h got %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic setp, input logic [5:0] p, input int nw, input int nr);
    logic ack;
    m.start_cond();
    if (setp) begin
      m.wbyte({SLAVE_ADDR, 1'b0}, ack);
      chk("write addr ack", 8'h01, {7'h00, ack});
      m.wbyte({2'b00, p}, ack);
      chk("pointer ack", 8'h01, {7'h00, ack});
      for (int i = 0; i < nw; i++) begin
        m.wbyte(wbuf[i], ack);
        chk("data ack", 8'h01, {7'h00, ack});
      end
      if (nr > 0) m.start_cond();
    end
    if (nr > 0) begin
      m.wbyte({SLAVE_ADDR, 1'b1}, ack);
      chk("read addr ack", 8'h01, {7'h00, ack});
      for (int i = 0; i < nr; i++) m.rbyte(i == nr - 1, rbuf[i]);
    end
    m.stop_cond();
  endtask

  task automatic ctrl_wr(input logic [7:0] d);
    wbuf[0] = d;
    xfer(1'b1, CTRL_ADDR, 1, 0);
  endtask

  task automatic ctrl_rd(input logic [7:0] exp);
    xfer(1'b1, CTRL_ADDR, 0, 1);
    chk("control", exp, rbuf[0]);
  endtask

  task automatic rises(output int n);
    logic p;
    n = 0;
    p = square_wave_pin;
    repeat (480) begin
      m.tick(1);
      if (square_wave_pin && !p) n++;
      p = square_wave_pin;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int         n, e;
    logic       ack;
    srst    = 1'b1;
    osc_run = 1'b1;
    for (int i = 0; i < 64; i++) ext_mem[i] = 8'(i) ^ 8'h5a;
    m.tick(10);
    srst = 1'b0;
    m.tick(40);
    ctrl_rd(CTRL_RESET);
    m.start_cond();
    m.wbyte({SLAVE_ADDR ^ 7'h01, 1'b0}, ack);
    chk("foreign addr ack", 8'h00, {7'h00, ack});
    m.stop_cond();
    ctrl_wr(8'h4c);
    ctrl_rd(8'h00);
    rises(n);
    chk("static low", 8'h00, {square_wave_pin, n[6:0]});
    ctrl_wr(8'h80);
    rises(n);
    chk("static high", 8'h80, {square_wave_pin, n[6:0]});
    // window of 1920 ns against a 12 ns tick worth 1/65536 s
    for (int i = 0; i < 4; i++) begin
      ctrl_wr(8'h10 | 8'(i));
      m.tick(40);
      rises(n);
      e = 1920 * hz[i] / (12 * 65536);
      chk("rises", 8'(e), (n - e <= 1 && e - n <= 1) ? 8'(e) : 8'(n));
    end
    ctrl_wr(8'h33);
    ctrl_rd(8'h13);
    osc_run = 1'b0;
    m.tick(100);
    osc_run = 1'b1;
    m.tick(40);
    ctrl_wr(8'h33);
    ctrl_rd(8'h33);
    ctrl_wr(8'h13);
    ctrl_rd(8'h13);
    wbuf[0] = 8'ha1;
    wbuf[1] = 8'ha2;
    wbuf[2] = 8'ha3;
    xfer(1'b1, 6'h3e, 3, 0);
    for (int i = 0; i < 3; i++) chk("ext write", wbuf[i], ext_mem[6'h3e + 6'(i)]);
    xfer(1'b1, 6'h3f, 0, 3);
    for (int i = 0; i < 3; i++) chk("ext read", rexp[i], rbuf[i]);
    m.half = 313;
    xfer(1'b0, 6'h00, 0, 1);
    chk("current pointer", 8'h02 ^ 8'h5a, rbuf[0]);
    chk("ack and data hold", 8'h00, 8'(m.hold_err));
    end_of_test();
  end
endmodule // rtc_serial_slave_sqw_control_tb_top
